// ==== inc/svmon_consts.vh ====
// Constants for the supply voltage monitor and reset sequencer
`ifndef SVMON_CONSTS_VH
`define SVMON_CONSTS_VH
// ---------------------------------------------------------------
// Register map (byte addresses, printed offset 0x36 kept as index)
// ---------------------------------------------------------------
`define MON1_CTRL_IDX 8'h36
`define ADDR_MON1_CTRL 10'h0D8
`define ADDR_STATUS 10'h000
`define ADDR_IRQ_STAT 10'h004
`define ADDR_IRQ_MASK 10'h008
`define ADDR_MON2_CTRL 10'h00C
`define ADDR_MSB 9
// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define B_RST_EN 0
`define B_BYPASS 1
`define B_RSVD 2
`define B_UNDEF 3
`define B_DIV_LO 4
`define B_DIV_HI 5
`define B_MODE 6
`define B_COND 7
// Reset values of the control register
`define MON1_RST_HW 8'h00
`define MON1_RST_POR 8'h41
`define MON2_RST 8'h00
// ---------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------
`define IRQ_MON2 0
`define IRQ_MON1 1
`define IRQ_W 2
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RELEASE_CYCLES 6'h20
`define MON2_DELAY_CYCLES 6'h20
`define SAMPLE_PERIODS 2'h3
`endif

// ==== src/cmp_sync.v ====
// Three-stage synchroniser with agreement check for a comparator level
`timescale 1ns/1ps
module cmp_sync (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Raw comparator level and clean output
	input wire raw_in,
	output reg level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// Stage one feeds stage two only; change taken when two and three agree
	// Resets high: the idle level, so no false edge follows reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_q <= s3_q;
		end
	end
endmodule

// ==== src/mon_filter.v ====
// Digital filter: samples a level on a divided clock, two samples agree
`include "svmon_consts.vh"
`timescale 1ns/1ps
module mon_filter (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Configuration
	input wire [1:0] div_sel,
	input wire bypass,
	// Level in and filtered level out
	input wire level_in,
	output reg level_q
);
	reg [2:0] pre_q;
	reg [1:0] tick_q;
	reg samp_q;
	reg div_hit;

	// Divider end count per select: by 1, 2, 4, 8
	always @* begin
		case (div_sel)
		2'h0: div_hit = 1'b1;
		2'h1: div_hit = pre_q[0];
		2'h2: div_hit = &pre_q[1:0];
		default: div_hit = &pre_q;
		endcase
	end

	// Sample every four divided periods; act when two samples match
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 3'h0;
			tick_q <= 2'h0;
			samp_q <= 1'b1;
			level_q <= 1'b1;
		end else if (bypass) begin
			pre_q <= 3'h0;
			tick_q <= 2'h0;
			samp_q <= level_in;
			level_q <= level_in;
		end else begin
			pre_q <= div_hit ? 3'h0 : pre_q + 3'h1;
			if (div_hit) begin
				if (tick_q == `SAMPLE_PERIODS) begin
					tick_q <= 2'h0;
					samp_q <= level_in;
					if (samp_q == level_in)
						level_q <= level_in;
				end else begin
					tick_q <= tick_q + 2'h1;
				end
			end
		end
	end
endmodule

// ==== src/supply_voltage_monitor_reset.v ====
// Supply voltage monitor: two detectors, reset release, AHB-Lite regs
//
// Functional notes
// - Detector one reset held while supply below threshold one, freed above
// - Detector two reset held below threshold two, freed after fixed delay
// - Readable detector two level status; none for detector one
// - Detector two interrupt: both edges filtered, selected edge unfiltered
// - Bits 5:4 divide slow clock by 1,2,4,8; sample every four periods
// - Control bit 0 enables detector one reset
// - Control bit 1 bypasses the digital filter
// - Reserved bit 2 written zero; may set on rewrite, software clears
// - Bit 3 read only, value undefined
// - Pin reset gives control value 0000X000b
// - Power-on or detector one reset gives 0100X001b
// - Control register kept through software, watchdog, detector two reset
// - Reset enable works only with circuit enable; software clears otherwise
// - Filter acts after two consecutive agreeing samples
// - Count 32 slow clock cycles after recovery before release
`include "svmon_consts.vh"
`timescale 1ns/1ps
module supply_voltage_monitor_reset (
	// AHB-Lite clock and reset (pin reset)
	input wire hclk,
	input wire hresetn,
	// Power-on indication, active low
	input wire por_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Analog comparators: high while supply above threshold
	input wire cmp1_above,
	input wire cmp2_above,
	// Circuit enables
	input wire det1_circuit_enable,
	input wire det2_circuit_enable,
	// Reset and interrupt outputs
	output reg mon1_reset_n,
	output reg mon2_reset_n,
	output reg irq
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [1:0] irq_stat_q;
	reg [1:0] irq_mask_q;
	reg wr_pend_q;
	reg [`ADDR_MSB:0] addr_q;
	reg por_seen_q;
	reg [5:0] rel1_q;
	reg [5:0] rel2_q;
	reg mon1_act_q;
	reg mon2_act_q;
	reg lvl2_prev_q;
	reg lvl1_prev_q;
	reg [31:0] rd_d;
	wire c1_sync;
	wire c2_sync;
	wire c1_filt;
	wire c2_filt;
	wire acc;
	wire rise2;
	wire fall2;
	wire ev2;
	wire ev1;
	wire por_sync_n;

	// ---------------------------------------------------------------
	// Comparator input path
	// ---------------------------------------------------------------
	// sync comparators
	cmp_sync u_sync1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.raw_in(cmp1_above),
		.level_q(c1_sync)
	);
	cmp_sync u_sync2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.raw_in(cmp2_above),
		.level_q(c2_sync)
	);
	// Power-on pin is asynchronous too; same three-stage path
	cmp_sync u_sync_por (
		.hclk(hclk),
		.hresetn(hresetn),
		.raw_in(por_n),
		.level_q(por_sync_n)
	);
	mon_filter u_filt1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.div_sel(ctrl1_q[`B_DIV_HI:`B_DIV_LO]),
		.bypass(ctrl1_q[`B_BYPASS]),
		.level_in(c1_sync),
		.level_q(c1_filt)
	);
	mon_filter u_filt2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.div_sel(ctrl2_q[`B_DIV_HI:`B_DIV_LO]),
		.bypass(ctrl2_q[`B_BYPASS]),
		.level_in(c2_sync),
		.level_q(c2_filt)
	);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	assign acc = hsel & hready & htrans[1];

	// Edge detection on filtered levels
	assign rise2 = c2_filt & ~lvl2_prev_q;
	assign fall2 = ~c2_filt & lvl2_prev_q;
	// both edges filtered, selected edge bypassed
	assign ev2 = det2_circuit_enable & ctrl2_q[`B_RST_EN] &
		~ctrl2_q[`B_MODE] &
		(ctrl2_q[`B_BYPASS] ?
		(ctrl2_q[`B_COND] ? fall2 : rise2) : (rise2 | fall2));
	assign ev1 = ~c1_filt & lvl1_prev_q;

	// Read mux on the address phase; undefined bit 3 returns zero here
	// Decoding the live address lets hrdata load one edge early,
	// so it already stands when the data phase ends
	always @* begin
		rd_d = 32'h0000_0000;
		case (haddr[`ADDR_MSB:0])
		`ADDR_MON1_CTRL: rd_d[7:0] = ctrl1_q & 8'hF7;
		`ADDR_MON2_CTRL: rd_d[7:0] = ctrl2_q;
		`ADDR_STATUS: rd_d[0] = c2_filt & det2_circuit_enable;
		`ADDR_IRQ_STAT: rd_d[1:0] = irq_stat_q;
		`ADDR_IRQ_MASK: rd_d[1:0] = irq_mask_q;
		default: rd_d = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Bus phases
	// ---------------------------------------------------------------
	// Zero wait state slave, always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= {(`ADDR_MSB+1){1'b0}};
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (acc) begin
				wr_pend_q <= hwrite;
				addr_q <= haddr[`ADDR_MSB:0];
			end else if (hready) begin
				wr_pend_q <= 1'b0;
			end
			// Loaded at the address edge, held until the next read
			// Limitation: a read right behind a write to the same
			// register returns the value from before that write
			if (acc & ~hwrite)
				hrdata <= rd_d;
		end
	end

	// Capture power-on after pin reset release, from the synced pin
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			por_seen_q <= 1'b0;
		else
			por_seen_q <= ~por_sync_n;
	end

	// ---------------------------------------------------------------
	// Detector one control register
	// ---------------------------------------------------------------
	// pin reset value; power-on or detector one reset value
	// software, watchdog and detector two resets leave it alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl1_q <= `MON1_RST_HW;
		end else if (por_seen_q | mon1_act_q) begin
			ctrl1_q <= `MON1_RST_POR;
		end else if (wr_pend_q && addr_q == `ADDR_MON1_CTRL) begin
			// plain storage; bit two kept as written
			ctrl1_q <= hwdata[7:0] & 8'hF7;
		end
	end

	// Detector two control and interrupt registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl2_q <= `MON2_RST;
			irq_mask_q <= 2'h0;
			irq_stat_q <= 2'h0;
		end else begin
			if (wr_pend_q && addr_q == `ADDR_MON2_CTRL)
				ctrl2_q <= hwdata[7:0] & 8'hF7;
			if (wr_pend_q && addr_q == `ADDR_IRQ_MASK)
				irq_mask_q <= hwdata[1:0];
			// Set wins over write-one clear
			irq_stat_q[`IRQ_MON2] <= ev2 | (irq_stat_q[`IRQ_MON2] &
				~(wr_pend_q && addr_q == `ADDR_IRQ_STAT &&
				hwdata[`IRQ_MON2]));
			irq_stat_q[`IRQ_MON1] <= ev1 | (irq_stat_q[`IRQ_MON1] &
				~(wr_pend_q && addr_q == `ADDR_IRQ_STAT &&
				hwdata[`IRQ_MON1]));
		end
	end

	// ---------------------------------------------------------------
	// Reset generation
	// ---------------------------------------------------------------
	// enable gated by circuit enable
	// hold below threshold one; count 32 before release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon1_act_q <= 1'b0;
			rel1_q <= 6'h00;
			lvl1_prev_q <= 1'b1;
			lvl2_prev_q <= 1'b1;
		end else begin
			lvl1_prev_q <= c1_filt;
			lvl2_prev_q <= c2_filt;
			if (det1_circuit_enable & ctrl1_q[`B_RST_EN] & ~c1_filt) begin
				mon1_act_q <= 1'b1;
				rel1_q <= 6'h00;
			end else if (mon1_act_q) begin
				if (rel1_q == `RELEASE_CYCLES - 6'h01)
					mon1_act_q <= 1'b0;
				else
					rel1_q <= rel1_q + 6'h01;
			end
		end
	end

	// detector two reset with fixed restart delay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon2_act_q <= 1'b0;
			rel2_q <= 6'h00;
		end else if (det2_circuit_enable & ctrl2_q[`B_RST_EN] &
			ctrl2_q[`B_MODE] & ~c2_filt) begin
			mon2_act_q <= 1'b1;
			rel2_q <= 6'h00;
		end else if (mon2_act_q) begin
			if (rel2_q == `MON2_DELAY_CYCLES - 6'h01)
				mon2_act_q <= 1'b0;
			else
				rel2_q <= rel2_q + 6'h01;
		end
	end

	// Registered outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon1_reset_n <= 1'b1;
			mon2_reset_n <= 1'b1;
			irq <= 1'b0;
		end else begin
			mon1_reset_n <= ~mon1_act_q;
			mon2_reset_n <= ~mon2_act_q;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule

// ==== bench/svmon_props.sv ====
// Port checks for the supply monitor
`include "svmon_consts.vh"
`timescale 1ns/1ps
module svmon_props (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus and supply side
	input wire por_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire cmp1_above,
	input wire cmp2_above,
	input wire mon1_reset_n,
	input wire mon2_reset_n,
	input wire irq
);
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
reg dp_q;
reg dw_q;
reg [9:0] da_q;
reg b2_q;
reg [5:0] hi1_q;
reg [5:0] hi2_q;
// Data phase tracking; bit 2 follows writes, clears on reload
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		dp_q <= 1'b0;
		dw_q <= 1'b0;
		da_q <= 10'h0;
		b2_q <= 1'b0;
	end else begin
		dp_q <= hsel & hready & htrans[1];
		dw_q <= hwrite;
		da_q <= haddr[9:0];
		if (!por_n || !mon1_reset_n)
			b2_q <= 1'b0;
		else if (dp_q && dw_q && da_q == `ADDR_MON1_CTRL)
			b2_q <= hwdata[2];
	end
end
// High run lengths, saturating so a long run stays legal
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hi1_q <= 6'h0;
		hi2_q <= 6'h0;
	end else begin
		hi1_q <= !cmp1_above ? 6'h0 : hi1_q + {5'h0, hi1_q != 6'h3F};
		hi2_q <= !cmp2_above ? 6'h0 : hi2_q + {5'h0, hi2_q != 6'h3F};
	end
end
wire rd1 = dp_q && !dw_q && da_q == `ADDR_MON1_CTRL;
property p_undef;
	rd1 |-> hrdata[3] == 1'b0 && hrdata[31:8] == 24'h0;
endproperty
a_undef: assert property (p_undef) else $error("bit 3 not zero");
property p_rsvd;
	rd1 |-> hrdata[2] == b2_q;
endproperty
a_rsvd: assert property (p_rsvd) else $error("bit 2 changed");
property p_rel1;
	$rose(mon1_reset_n) |-> hi1_q >= 6'h20;
endproperty
a_rel1: assert property (p_rel1) else $error("early release 1");
property p_rel2;
	$rose(mon2_reset_n) |-> hi2_q >= 6'h20;
endproperty
a_rel2: assert property (p_rel2) else $error("early release 2");
property p_sync1;
	mon1_reset_n && $fell(cmp1_above) |=> mon1_reset_n [*4];
endproperty
a_sync1: assert property (p_sync1) else $error("reset 1 too fast");
property p_sync2;
	mon2_reset_n && $fell(cmp2_above) |=> mon2_reset_n [*4];
endproperty
a_sync2: assert property (p_sync2) else $error("reset 2 too fast");
property p_irq_mask;
	dp_q && dw_q && da_q == `ADDR_IRQ_MASK && hwdata == 32'h0
		|-> ##[1:2] !irq;
endproperty
a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
property p_low2;
	$fell(mon2_reset_n) |=> !mon2_reset_n [*8];
endproperty
a_low2: assert property (p_low2) else $error("short reset 2");
c_rel1: cover property ($rose(mon1_reset_n));
c_rel2: cover property ($rose(mon2_reset_n));
c_irq: cover property ($rose(irq));
endmodule
bind supply_voltage_monitor_reset svmon_props u_props (.hclk(hclk),
	.hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .cmp1_above(cmp1_above), .cmp2_above(cmp2_above),
	.mon1_reset_n(mon1_reset_n), .mon2_reset_n(mon2_reset_n), .irq(irq));

// ==== bench/supply_cmp_model.sv ====
// Behavioural model of the two supply comparators
`timescale 1ns/1ps
module supply_cmp_model #(
	parameter [7:0] TH1 = 8'h40,
	parameter [7:0] TH2 = 8'h60
) (
	// Supply level in
	input wire [7:0] vcc,
	// Levels, high above threshold
	output wire cmp1_above,
	output wire cmp2_above
);
// Analog delay keeps edges off the clock grid
assign #37 cmp1_above = vcc > TH1;
assign #37 cmp2_above = vcc > TH2;
endmodule

// ==== bench/supply_voltage_monitor_reset_tb_top.sv ====
// Self-checking bench for the supply monitor
`include "svmon_consts.vh"
`timescale 1ns/1ps
module supply_voltage_monitor_reset_tb_top;
// --------
// Signals and model state
// --------
reg hclk = 1'b0;
reg hresetn = 1'b0;
reg por_n = 1'b1;
reg hsel = 1'b0;
reg [31:0] haddr = 32'h0;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [31:0] hwdata = 32'h0;
reg [7:0] vcc = 8'h80;
reg det1_en = 1'b1;
reg det2_en = 1'b1;
wire [31:0] hrdata;
wire hreadyout, hresp, cmp1, cmp2, rst1_n, rst2_n, irq;
reg [31:0] r;
reg [31:0] rv;
integer mismatches = 0;
integer num_checks = 0;
integer cyc = 0;
integer seed = 32'h05158AC6;
integer i;
integer n;
integer m_c1 = 0;
supply_cmp_model cmp (.vcc(vcc), .cmp1_above(cmp1), .cmp2_above(cmp2));
supply_voltage_monitor_reset uut (.hclk(hclk), .hresetn(hresetn),
	.por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.cmp1_above(cmp1), .cmp2_above(cmp2), .det1_circuit_enable(det1_en),
	.det2_circuit_enable(det2_en), .mon1_reset_n(rst1_n),
	.mon2_reset_n(rst2_n), .irq(irq));
// Clock and hang guard
always #50 hclk = ~hclk;
always @(posedge hclk) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		mismatches = mismatches + 1;
		wrap_up;
	end
end
task wrap_up;
	begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	end
endtask
// Single zero-or-more wait transfer, held until hready
task xfer(input w, input [9:0] a, input [31:0] d);
	begin
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	end
endtask
task wr(input [9:0] a, input [31:0] d);
	begin
		xfer(1'b1, a, d);
		if (a == `ADDR_MON1_CTRL) m_c1 = d & 32'hF7;
	end
endtask
task rd(input [9:0] a, input [31:0] e);
	begin
		xfer(1'b0, a, 32'h0);
		chk(r, e);
	end
endtask
function pick(input integer s);
	pick = s == 0 ? rst1_n : s == 1 ? rst2_n : irq;
endfunction
// Bounded wait for a level, n counts edges
task wt(input integer s, input v, input integer lim);
	begin
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge hclk);
			n = n + 1;
		end
	end
endtask
initial begin
	repeat (20) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	rd(`ADDR_MON1_CTRL, 32'h0);
	rd(10'h010, 32'h0);
	$display("test reset values done");
	// Software keeps bit 2 clear and bits 6, 7 paired with 0, 1
	for (i = 0; i < 8; i = i + 1) begin
		rv = $random(seed);
		rv[5:4] = i[1:0];
		rv[2] = 1'b0;
		if (rv[0]) rv[6] = 1'b1;
		if (rv[1]) rv[7] = 1'b1;
		wr(`ADDR_MON1_CTRL, rv);
		rd(`ADDR_MON1_CTRL, m_c1);
	end
	$display("test control fields done");
	wr(`ADDR_MON1_CTRL, 32'h71);
	vcc <= 8'h30;
	wt(0, 0, 400);
	chk(rst1_n, 1'b0);
	vcc <= 8'h80;
	wt(0, 1, 400);
	chk(n >= 32 && n < 50, 1'b1);
	m_c1 = 32'h41;
	rd(`ADDR_MON1_CTRL, m_c1);
	$display("test filtered reset done");
	det1_en <= 1'b0;
	wr(`ADDR_MON1_CTRL, 32'hC3);
	vcc <= 8'h30;
	wt(0, 0, 100);
	chk(rst1_n, 1'b1);
	det1_en <= 1'b1;
	wt(0, 0, 20);
	chk(rst1_n, 1'b0);
	vcc <= 8'h80;
	wt(0, 1, 100);
	chk(n >= 32 && n < 50, 1'b1);
	$display("test bypass reset done");
	wr(`ADDR_MON1_CTRL, 32'h51);
	wr(`ADDR_MON2_CTRL, 32'hC1);
	vcc <= 8'h50;
	wt(1, 0, 200);
	chk(rst2_n, 1'b0);
	rd(`ADDR_STATUS, 32'h0);
	vcc <= 8'h80;
	wt(1, 1, 200);
	chk(n >= 32 && n < 50, 1'b1);
	rd(`ADDR_STATUS, 32'h1);
	det2_en <= 1'b0;
	rd(`ADDR_STATUS, 32'h0);
	det2_en <= 1'b1;
	rd(`ADDR_MON1_CTRL, 32'h51);
	wr(`ADDR_MON2_CTRL, 32'h0);
	por_n <= 1'b0;
	repeat (3) @(posedge hclk);
	por_n <= 1'b1;
	repeat (8) @(posedge hclk);
	chk(rst1_n, 1'b1);
	rd(`ADDR_MON1_CTRL, 32'h41);
	$display("test second detector done");
	wr(`ADDR_IRQ_STAT, 32'h3);
	wr(`ADDR_MON2_CTRL, 32'h1);
	wr(`ADDR_IRQ_MASK, 32'h1);
	vcc <= 8'h50;
	wt(2, 1, 200);
	chk(irq, 1'b1);
	rd(`ADDR_IRQ_STAT, 32'h1);
	wr(`ADDR_IRQ_STAT, 32'h1);
	wt(2, 0, 4);
	chk(irq, 1'b0);
	vcc <= 8'h80;
	wt(2, 1, 200);
	chk(irq, 1'b1);
	wr(`ADDR_IRQ_MASK, 32'h0);
	wt(2, 0, 4);
	chk(irq, 1'b0);
	// Filter bypassed, rising crossing selected: fall must stay quiet
	wr(`ADDR_IRQ_STAT, 32'h1);
	wr(`ADDR_MON2_CTRL, 32'h3);
	wr(`ADDR_IRQ_MASK, 32'h1);
	vcc <= 8'h50;
	wt(2, 1, 60);
	chk(irq, 1'b0);
	vcc <= 8'h80;
	wt(2, 1, 60);
	chk(irq, 1'b1);
	rd(`ADDR_IRQ_STAT, 32'h1);
	$display("test interrupt done");
	wrap_up;
end
endmodule
